// ---- agod_defs.svh ----
`ifndef AGOD_DEFS_SVH
`define AGOD_DEFS_SVH
// How it works
// RQ1: Byte 0x2f alone decodes as decimal adjust after subtraction.
// RQ2: Group byte 1111011w, middle field 100, selects unsigned multiply.
// RQ3: Group byte with middle field 101 selects signed multiply.
// RQ4: Group byte with middle field 110 selects unsigned divide.
// RQ5: Group byte with middle field 111 selects signed divide.
// RQ6: Byte 0xd4 is ascii adjust after product and consumes one constant byte.
// RQ7: Bytes 0xd5 then 0x0a decode as ascii adjust before quotient.
// RQ8: Byte 0x98 alone is byte to word sign extension.
// RQ9: Byte 0x99 alone is word to doubleword sign extension.
// RQ10: Group low bit picks byte or word; mod and r/m decode as usual.
`define AGOD_OP_DAS_BYTE 8'h2f
`define AGOD_OP_GROUP_HI 7'h7b
`define AGOD_OP_ASC_PROD 8'hd4
`define AGOD_OP_ASC_QUOT 8'hd5
`define AGOD_ASC_QUOT_K 8'h0a
`define AGOD_OP_BYTE_EXT 8'h98
`define AGOD_OP_WORD_EXT 8'h99
`define AGOD_REG_UMUL 3'h4
`define AGOD_REG_SMUL 3'h5
`define AGOD_REG_UDIV 3'h6
`define AGOD_REG_SDIV 3'h7
`define AGOD_MOD_LSB 6
`define AGOD_REG_LSB 3
`endif

// ---- agod_pkg.sv ----
package agod_pkg;
    typedef enum logic [3:0] {
        AGOD_NONE,
        AGOD_DECIMAL_ADJUST_SUBTRACT,
        AGOD_UNSIGNED_MULTIPLY,
        AGOD_SIGNED_MULTIPLY,
        AGOD_UNSIGNED_DIVIDE,
        AGOD_SIGNED_DIVIDE,
        AGOD_ASCII_ADJUST_AFTER_PRODUCT,
        AGOD_ASCII_ADJUST_BEFORE_QUOTIENT,
        AGOD_BYTE_TO_WORD_EXTEND,
        AGOD_WORD_TO_DOUBLE_EXTEND
    } agod_op_e;
    typedef enum {
        AGOD_ST_FIRST,
        AGOD_ST_GROUP,
        AGOD_ST_PROD,
        AGOD_ST_QUOT
    } agod_state_e;
endpackage : agod_pkg

// ---- agod_group.sv ----
`include "agod_defs.svh"
// Decode of the group's addressing byte into an operation
module agod_group (
    // Addressing byte
    input wire logic [7:0] i_modrm,
    // Decoded selection
    output agod_pkg::agod_op_e o_op
);
    always_comb begin
        case (i_modrm[`AGOD_REG_LSB +: 3])
            `AGOD_REG_UMUL: o_op = agod_pkg::AGOD_UNSIGNED_MULTIPLY; // RQ2
            `AGOD_REG_SMUL: o_op = agod_pkg::AGOD_SIGNED_MULTIPLY; // RQ3
            `AGOD_REG_UDIV: o_op = agod_pkg::AGOD_UNSIGNED_DIVIDE; // RQ4
            `AGOD_REG_SDIV: o_op = agod_pkg::AGOD_SIGNED_DIVIDE; // RQ5
            default: o_op = agod_pkg::AGOD_NONE;
        endcase
    end
endmodule : agod_group

// ---- agod_decoder.sv ----
`include "agod_defs.svh"
module agod_decoder (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Opcode byte stream from fetch
    input wire logic i_valid,
    input wire logic [7:0] i_byte,
    // Decoded instruction
    output logic o_valid,
    output agod_pkg::agod_op_e o_op,
    output logic o_word,
    output logic [1:0] o_mode,
    output logic [2:0] o_rm,
    output logic [7:0] o_imm,
    output logic o_illegal
);
    // =============================================================
    // State
    typedef struct packed {
        agod_pkg::agod_state_e st;
        logic word;
        logic valid;
        agod_pkg::agod_op_e op;
        logic ow;
        logic [1:0] mode;
        logic [2:0] rm;
        logic [7:0] imm;
        logic illegal;
    } agod_reg_s;

    agod_reg_s r;
    agod_reg_s next_r;
    agod_pkg::agod_op_e grp_op;

    agod_group u_group (
        .i_modrm(i_byte),
        .o_op(grp_op)
    );

    // =============================================================
    // Next state
    always_comb begin
        next_r = r;
        next_r.valid = 1'b0;
        next_r.illegal = 1'b0;
        if (i_valid) begin
            case (r.st)
                agod_pkg::AGOD_ST_FIRST: begin
                    next_r.ow = 1'b0;
                    next_r.mode = 2'h0;
                    next_r.rm = 3'h0;
                    next_r.imm = 8'h00;
                    if (i_byte == `AGOD_OP_DAS_BYTE) begin
                        next_r.valid = 1'b1; // RQ1
                        next_r.op = agod_pkg::AGOD_DECIMAL_ADJUST_SUBTRACT;
                    end else if (i_byte == `AGOD_OP_BYTE_EXT) begin
                        next_r.valid = 1'b1; // RQ8
                        next_r.op = agod_pkg::AGOD_BYTE_TO_WORD_EXTEND;
                    end else if (i_byte == `AGOD_OP_WORD_EXT) begin
                        next_r.valid = 1'b1; // RQ9
                        next_r.ow = 1'b1;
                        next_r.op = agod_pkg::AGOD_WORD_TO_DOUBLE_EXTEND;
                    end else if (i_byte[7:1] == `AGOD_OP_GROUP_HI) begin
                        next_r.word = i_byte[0]; // RQ10
                        next_r.st = agod_pkg::AGOD_ST_GROUP;
                    end else if (i_byte == `AGOD_OP_ASC_PROD) begin
                        next_r.st = agod_pkg::AGOD_ST_PROD; // RQ6
                    end else if (i_byte == `AGOD_OP_ASC_QUOT) begin
                        next_r.st = agod_pkg::AGOD_ST_QUOT; // RQ7
                    end else begin
                        // Opcodes outside this group are not ours
                        next_r.valid = 1'b1;
                        next_r.op = agod_pkg::AGOD_NONE;
                    end
                end
                agod_pkg::AGOD_ST_GROUP: begin
                    next_r.st = agod_pkg::AGOD_ST_FIRST;
                    next_r.valid = 1'b1;
                    next_r.op = grp_op; // RQ2 RQ3 RQ4 RQ5
                    next_r.ow = r.word; // RQ10
                    next_r.mode = i_byte[`AGOD_MOD_LSB +: 2]; // RQ10
                    next_r.rm = i_byte[2:0];
                    // Middle fields 000..011 are other group members
                    next_r.illegal = (grp_op == agod_pkg::AGOD_NONE);
                end
                agod_pkg::AGOD_ST_PROD: begin
                    next_r.st = agod_pkg::AGOD_ST_FIRST;
                    next_r.valid = 1'b1;
                    next_r.op = agod_pkg::AGOD_ASCII_ADJUST_AFTER_PRODUCT;
                    next_r.imm = i_byte; // RQ6
                end
                agod_pkg::AGOD_ST_QUOT: begin
                    next_r.st = agod_pkg::AGOD_ST_FIRST;
                    next_r.valid = 1'b1;
                    next_r.imm = i_byte;
                    // Only the documented constant is accepted
                    if (i_byte == `AGOD_ASC_QUOT_K) begin
                        next_r.op = agod_pkg::AGOD_ASCII_ADJUST_BEFORE_QUOTIENT; // RQ7
                    end else begin
                        next_r.op = agod_pkg::AGOD_NONE;
                        next_r.illegal = 1'b1;
                    end
                end
                default: begin
                    next_r.st = agod_pkg::AGOD_ST_FIRST;
                end
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign o_valid = r.valid;
    assign o_op = r.op;
    assign o_word = r.ow;
    assign o_mode = r.mode;
    assign o_rm = r.rm;
    assign o_imm = r.imm;
    assign o_illegal = r.illegal;

    // =============================================================
    // Checks
    a_das_single: assert property (@(posedge i_clock) disable iff (i_rst)
        r.st == agod_pkg::AGOD_ST_FIRST && i_valid
        && i_byte == `AGOD_OP_DAS_BYTE |=> o_valid
        && o_op == agod_pkg::AGOD_DECIMAL_ADJUST_SUBTRACT) // RQ1
        else $error("decimal adjust not decoded");
    a_umul_sel: assert property (@(posedge i_clock) disable iff (i_rst)
        r.st == agod_pkg::AGOD_ST_GROUP && i_valid
        && i_byte[5:3] == `AGOD_REG_UMUL
        |=> o_op == agod_pkg::AGOD_UNSIGNED_MULTIPLY) // RQ2
        else $error("unsigned multiply wrong");
    a_smul_sel: assert property (@(posedge i_clock) disable iff (i_rst)
        r.st == agod_pkg::AGOD_ST_GROUP && i_valid
        && i_byte[5:3] == `AGOD_REG_SMUL
        |=> o_op == agod_pkg::AGOD_SIGNED_MULTIPLY) // RQ3
        else $error("signed multiply wrong");
    // Keyed on the group state so a fetch pause still reaches it
    a_udiv_sel: assert property (@(posedge i_clock) disable iff (i_rst)
        r.st == agod_pkg::AGOD_ST_GROUP && i_valid
        && i_byte[`AGOD_REG_LSB +: 3] == `AGOD_REG_UDIV
        |=> o_valid && o_op == agod_pkg::AGOD_UNSIGNED_DIVIDE) // RQ4
        else $error("unsigned divide wrong");
    a_sdiv_sel: assert property (@(posedge i_clock) disable iff (i_rst)
        r.st == agod_pkg::AGOD_ST_GROUP && i_valid
        && i_byte[5:3] == `AGOD_REG_SDIV
        |=> o_op == agod_pkg::AGOD_SIGNED_DIVIDE && !o_illegal) // RQ5
        else $error("signed divide wrong");
    a_prod_imm: assert property (@(posedge i_clock) disable iff (i_rst)
        r.st == agod_pkg::AGOD_ST_PROD && i_valid
        |=> o_valid && o_imm == $past(i_byte)
        && o_op == agod_pkg::AGOD_ASCII_ADJUST_AFTER_PRODUCT) // RQ6
        else $error("ascii product constant lost");
    a_quot_pair: assert property (@(posedge i_clock) disable iff (i_rst)
        r.st == agod_pkg::AGOD_ST_FIRST && i_valid
        && i_byte == `AGOD_OP_ASC_QUOT |=> !o_valid) // RQ7
        else $error("ascii quotient decoded early");
    a_byte_ext: assert property (@(posedge i_clock) disable iff (i_rst)
        r.st == agod_pkg::AGOD_ST_FIRST && i_valid
        && i_byte == `AGOD_OP_BYTE_EXT
        |=> o_op == agod_pkg::AGOD_BYTE_TO_WORD_EXTEND) // RQ8
        else $error("byte extend wrong");
    a_word_ext: assert property (@(posedge i_clock) disable iff (i_rst)
        r.st == agod_pkg::AGOD_ST_FIRST && i_valid
        && i_byte == `AGOD_OP_WORD_EXT
        |=> o_op == agod_pkg::AGOD_WORD_TO_DOUBLE_EXTEND) // RQ9
        else $error("word extend wrong");
    a_width_bit: assert property (@(posedge i_clock) disable iff (i_rst)
        r.st == agod_pkg::AGOD_ST_FIRST && i_valid
        && i_byte[7:1] == `AGOD_OP_GROUP_HI ##1 i_valid
        |=> o_word == $past(i_byte[0], 2)) // RQ10
        else $error("width bit wrong");
    c_group: cover property (@(posedge i_clock)
        o_valid && o_op == agod_pkg::AGOD_SIGNED_DIVIDE);
    c_quot: cover property (@(posedge i_clock)
        o_valid && o_op == agod_pkg::AGOD_ASCII_ADJUST_BEFORE_QUOTIENT);
    c_bad: cover property (@(posedge i_clock) o_illegal);
endmodule : agod_decoder

// ---- agod_fetch_model.sv ----
// ==========
// Fetch queue model
module agod_fetch_model (
    // Clock
    input wire logic i_clock,
    // Byte stream toward the decoder
    output logic o_valid,
    output logic [7:0] o_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_valid = 1'b0;
        o_byte = 8'h00;
    end
    // Called at a falling edge, returns at the next one
    task automatic send(input logic [7:0] b);
        o_valid = 1'b1;
        o_byte = b;
        @(negedge i_clock);
    endtask : send
    // Stale byte inverted so it never passes for data
    task automatic idle(input int n);
        o_valid = 1'b0;
        o_byte = ~o_byte;
        repeat (n) @(negedge i_clock);
    endtask : idle
endmodule : agod_fetch_model

// ---- test_arith_group_opcode_decoder.sv ----
// ==========
// Decoder bench
module test_arith_group_opcode_decoder;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clock;
    logic i_rst;
    logic i_valid;
    logic [7:0] i_byte;
    logic o_valid;
    agod_pkg::agod_op_e o_op;
    logic o_word;
    logic [1:0] o_mode;
    logic [2:0] o_rm;
    logic [7:0] o_imm;
    logic o_illegal;
    int errors = 0;
    int total_checks = 0;
    agod_fetch_model fetch_u (.i_clock(i_clock), .o_valid(i_valid),
        .o_byte(i_byte));
    agod_decoder dut_u (.i_clock(i_clock), .i_rst(i_rst),
        .i_valid(i_valid), .i_byte(i_byte), .o_valid(o_valid),
        .o_op(o_op), .o_word(o_word), .o_mode(o_mode), .o_rm(o_rm),
        .o_imm(o_imm), .o_illegal(o_illegal));
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    task automatic conclude;
        if (errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task automatic feed(input logic [7:0] b);
        fetch_u.send(b);
    endtask : feed
    task automatic pause(input int n);
        fetch_u.idle(n);
    endtask : pause
    // Flags are word, mode, r/m, illegal
    task automatic chk(input agod_pkg::agod_op_e op, input logic [6:0] f,
        input logic [7:0] imm);
        int n;
        n = 0;
        pause(0);
        while (o_valid !== 1'b1 && n < 4) begin
            @(negedge i_clock);
            n++;
        end
        if (n == 4) begin
            errors++;
            conclude();
        end
        cmp({4'h0, o_op}, {4'h0, op});
        cmp({1'b0, o_word, o_mode, o_rm, o_illegal}, {1'b0, f});
        cmp(o_imm, imm);
        @(negedge i_clock);
        cmp({7'h00, o_valid}, 8'h00);
    endtask : chk
    task automatic reset_and_check;
        i_rst = 1'b1;
        repeat (6) @(negedge i_clock);
        i_rst = 1'b0;
        cmp({4'h0, o_op}, 8'h00);
        cmp({o_valid, o_word, o_mode, o_rm, o_illegal}, 8'h00);
        cmp(o_imm, 8'h00);
    endtask : reset_and_check
    task automatic t_singles;
        feed(8'h2f);
        chk(agod_pkg::AGOD_DECIMAL_ADJUST_SUBTRACT, 7'h00, 8'h00);
        feed(8'h98);
        chk(agod_pkg::AGOD_BYTE_TO_WORD_EXTEND, 7'h00, 8'h00);
        feed(8'h99);
        chk(agod_pkg::AGOD_WORD_TO_DOUBLE_EXTEND, 7'h40, 8'h00);
        feed(8'h2e);
        chk(agod_pkg::AGOD_NONE, 7'h00, 8'h00);
    endtask : t_singles
    // Fetch slows down more for each field value
    task automatic t_group;
        agod_pkg::agod_op_e g [4];
        g = '{agod_pkg::AGOD_UNSIGNED_MULTIPLY,
            agod_pkg::AGOD_SIGNED_MULTIPLY,
            agod_pkg::AGOD_UNSIGNED_DIVIDE, agod_pkg::AGOD_SIGNED_DIVIDE};
        for (int r = 4; r < 8; r++) begin
            feed({7'h7b, r[0]});
            if (r > 4) pause(r - 4);
            feed({2'(r), 3'(r), 3'(7 - r)});
            chk(g[r-4], {r[0], 2'(r), 3'(7 - r), 1'b0},
                8'h00);
        end
    endtask : t_group
    task automatic t_ascii;
        feed(8'hd4);
        feed(8'h3c);
        chk(agod_pkg::AGOD_ASCII_ADJUST_AFTER_PRODUCT, 7'h00, 8'h3c);
        feed(8'hd5);
        pause(2);
        feed(8'h0a);
        chk(agod_pkg::AGOD_ASCII_ADJUST_BEFORE_QUOTIENT, 7'h00, 8'h0a);
    endtask : t_ascii
    // Foreign middle fields and a wrong constant both flag illegal
    task automatic t_illegal;
        feed(8'hf6);
        feed(8'hd5);
        chk(agod_pkg::AGOD_NONE, 7'h3b, 8'h00);
        feed(8'hd5);
        feed(8'h0b);
        chk(agod_pkg::AGOD_NONE, 7'h01, 8'h0b);
    endtask : t_illegal
    // Reset mid-instruction must drop the pending group byte
    task automatic t_mid_reset;
        feed(8'hf7);
        pause(0);
        reset_and_check();
        feed(8'h98);
        chk(agod_pkg::AGOD_BYTE_TO_WORD_EXTEND, 7'h00, 8'h00);
    endtask : t_mid_reset
    initial begin
        i_rst = 1'b1;
        reset_and_check();
        t_singles();
        t_group();
        t_ascii();
        t_illegal();
        t_mid_reset();
        conclude();
    end
endmodule : test_arith_group_opcode_decoder
